// ==== design/cd_dsp_defs.vh ====
// constants for the command port, control registers and frame sync protection
// assumes 8-bit commands: address nibble high, data nibble low
//
// Function
// - host shifts bits on data/clock; latch loads word into addressed register
// - zero-cross-mute bit 1 enables zero-cross muting, 0 disables it
// - phase-servo-source bit: 0 frame sync reference, 1 base counters
// - crc-include bit 1 puts crc-good on subcode-q output during subcode sync
// - protection count bits 00/01/10/11 select 2/4/8/13 consecutive insertions
// - window bit 0 gives +-3 channel bits, 1 gives +-7
// - attenuation bit gives -12 dB; else mute input gives full mute
// - writing lower/upper track count loads that nibble of tracking counter
// - track count taken on rising edge of command latch
// - status pin shows jump-complete after lower, count pulse after upper
// - bottom-hold clock is frame clock /32 when 0, /16 when 1
// - peak-hold clock is frame clock /4 when 0, /2 when 1
// - gain bit 0 reduces speed-mode drive by 12 dB, 1 none
// - spindle mode codes decode forward, reverse, speed, hspeed, phase, auto, vco, stop
// - speed code 0000 normal, 0011 double speed
// - de-emphasis bit 1 selects internal digital, 0 external analog
// - reset clears de-emphasis bit 1
// - sync inside window accepted, outside ignored
// - missing sync in window replaced by internally generated sync
// - insertions reaching count raise unlock and accept next sync unconditionally
// - accepted sync clears unlock and restores windowed acceptance
// - lock flag high only when detected sync coincides with generated sync
`ifndef CD_DSP_DEFS_VH
`define CD_DSP_DEFS_VH

`define CMD_WIDTH 8
`define CMD_ADDR_HI 7
`define CMD_ADDR_LO 4
`define CMD_DATA_HI 3
`define REG_RESET 4'h0

`define ADDR_DEEMPH 4'h8
`define ADDR_DATA_CONTROL 4'h9
`define ADDR_SYNC_PROT 4'hA
`define ADDR_TRK_LOWER 4'hB
`define ADDR_TRK_UPPER 4'hC
`define ADDR_HOLD_GAIN 4'hD
`define ADDR_SPINDLE_MODE 4'hE
`define ADDR_SPEED 4'hF
`define STATUS_SEL_RESET 4'h0

`define BIT_ZERO_CROSS 3
`define BIT_PHASE_SRC 1
`define BIT_CRC_INCLUDE 0
`define BIT_PROT_HI 3
`define BIT_PROT_LO 2
`define BIT_WINDOW 1
`define BIT_ATTEN 0
`define BIT_BOTTOM_HOLD 2
`define BIT_PEAK_HOLD 1
`define BIT_GAIN 0
`define BIT_DEEMPH 1

`define MODE_FORWARD 4'h8
`define MODE_REVERSE 4'hA
`define MODE_SPEED 4'hE
`define MODE_HSPEED 4'hC
`define MODE_PHASE 4'hF
`define MODE_XPHSP 4'h6
`define MODE_VPHSP 4'h5
`define MODE_STOP 4'h0

`define SPEED_NORMAL 4'h0
`define SPEED_DOUBLE 4'h3

`define PROT_COUNT_00 4'h2
`define PROT_COUNT_01 4'h4
`define PROT_COUNT_10 4'h8
`define PROT_COUNT_11 4'hD
`define WIN_NARROW 10'h003
`define WIN_WIDE 10'h007
`define FRAME_BITS 588

`define HOLD_DIV32_LAST 5'h1F
`define HOLD_DIV16_LAST 4'hF
`define HOLD_DIV4_LAST 2'h3
`define HOLD_DIV2_LAST 1'h1

`endif

// ==== design/frame_sync_protect.v ====
// frame sync protect and insert: window check, insertion, lock and unlock flags
// assumes bit_tick_i marks one channel bit and sync_det_i coincides with a tick
`timescale 1ns/1ps
`default_nettype none
`include "cd_dsp_defs.vh"
module frame_sync_protect #(
    parameter FRAME_LEN = `FRAME_BITS,
    parameter CW = 10
) (
    // clock and reset
    input wire clk_sys_i,
    input wire rst_n_i,
    // settings
    input wire [1:0] prot_sel_i,
    input wire window_wide_i,
    // channel bit timing and detector
    input wire bit_tick_i,
    input wire sync_det_i,
    // results
    output reg frame_sync_o,
    output reg sync_inserted_o,
    output reg sync_lock_flag_o,
    output reg sync_unlock_flag_o
);
    localparam [CW-1:0] LAST = FRAME_LEN - 1;
    localparam [CW-1:0] FLEN = FRAME_LEN;
    reg [CW-1:0] pos_q;
    reg [3:0] miss_q;
    reg got_q;
    reg [3:0] limit;
    reg [CW-1:0] half_win;
    wire in_win;
    wire accept;

    always @* begin
        case (prot_sel_i)
            2'b00: limit = `PROT_COUNT_00;
            2'b01: limit = `PROT_COUNT_01;
            2'b10: limit = `PROT_COUNT_10;
            default: limit = `PROT_COUNT_11;
        endcase
        half_win = window_wide_i ? `WIN_WIDE : `WIN_NARROW;
    end

    assign in_win = (pos_q >= FLEN - half_win) || (pos_q <= half_win);
    assign accept = bit_tick_i && sync_det_i && !got_q && (in_win || sync_unlock_flag_o);

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pos_q <= {CW{1'b0}};
            miss_q <= 4'h0;
            got_q <= 1'b0;
            frame_sync_o <= 1'b0;
            sync_inserted_o <= 1'b0;
            sync_lock_flag_o <= 1'b0;
            sync_unlock_flag_o <= 1'b0;
        end else begin
            frame_sync_o <= 1'b0;
            sync_inserted_o <= 1'b0;
            if (accept) begin
                // detected sync defines position zero
                pos_q <= {{(CW-1){1'b0}}, 1'b1};
                got_q <= 1'b1;
                miss_q <= 4'h0;
                frame_sync_o <= 1'b1;
                sync_unlock_flag_o <= 1'b0;
                sync_lock_flag_o <= (pos_q == {CW{1'b0}});
            end else if (bit_tick_i) begin
                pos_q <= (pos_q == LAST) ? {CW{1'b0}} : pos_q + 1'b1;
                if (pos_q == half_win) begin
                    got_q <= 1'b0;
                    if (!got_q) begin
                        frame_sync_o <= 1'b1;
                        sync_inserted_o <= 1'b1;
                        sync_lock_flag_o <= 1'b0;
                        if (miss_q != 4'hF)
                            miss_q <= miss_q + 1'b1;
                        if (miss_q + 1'b1 >= limit)
                            sync_unlock_flag_o <= 1'b1;
                    end
                end
            end
        end
    end
endmodule // frame_sync_protect
`default_nettype wire

// ==== design/cd_dsp_control_registers.v ====
// serial command port, control registers, track counter, spindle mode pins
// assumes host pins are asynchronous; ticks and datapath inputs share clk_sys_i
`timescale 1ns/1ps
`default_nettype none
`include "cd_dsp_defs.vh"
module cd_dsp_control_registers #(
    parameter FRAME_LEN = `FRAME_BITS,
    parameter NPIN = 4
) (
    // clock and reset
    input wire clk_sys_i,
    input wire nrst_i,
    // host command port pins
    input wire command_clock_i,
    input wire command_data_i,
    input wire command_latch_i,
    // external mute pin
    input wire mute_pin_i,
    // timing ticks from the clock generator
    input wire crystal_frame_clock_i,
    input wire bit_tick_i,
    // frame sync detector
    input wire sync_det_i,
    // subcode inputs
    input wire subcode_q_data_i,
    input wire crc_good_indication_i,
    input wire subcode_sync_signal_i,
    // tracking counter status
    input wire jump_complete_n_i,
    input wire track_count_pulse_n_i,
    // spindle datapath results
    input wire speed_drive_i,
    input wire speed_drive_en_i,
    input wire phase_drive_i,
    input wire phase_velocity_i,
    // audio control
    output reg zero_cross_mute_o,
    output reg mute_full_o,
    output reg atten_12db_o,
    output reg deemph_internal_o,
    output reg double_speed_o,
    // servo control
    output reg phase_src_base_o,
    output reg bottom_hold_tick_o,
    output reg peak_hold_tick_o,
    output reg gain_reduce_o,
    // tracking counter
    output reg [7:0] track_count_o,
    output reg status_output_pin_o,
    // subcode q output
    output reg subcode_q_serial_out_o,
    // frame sync protection
    output wire frame_sync_o,
    output wire sync_inserted_o,
    output wire sync_lock_flag_o,
    output wire sync_unlock_flag_o,
    // spindle pins, output enables low while driven, servo enable high while running
    output reg spindle_drive_output_o,
    output reg spindle_drive_oe_n_o,
    output reg spindle_velocity_output_o,
    output reg spindle_velocity_oe_n_o,
    output reg spindle_filter_control_o,
    output reg spindle_filter_oe_n_o,
    output reg spindle_servo_enable_o
);
    // reset release
    reg [1:0] rst_sync_q;
    wire rst_n;

    always @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i)
            rst_sync_q <= 2'b00;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // pin synchronisers: a change counts once stages two and three agree
    wire [NPIN-1:0] pin_raw;
    reg [NPIN-1:0] pin_s1_q;
    reg [NPIN-1:0] pin_s2_q;
    reg [NPIN-1:0] pin_s3_q;
    reg [NPIN-1:0] pin_q;
    reg [NPIN-1:0] pin_prev_q;
    wire [NPIN-1:0] pin_rise;

    assign pin_raw = {mute_pin_i, command_latch_i, command_data_i, command_clock_i};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_pin
            always @(posedge clk_sys_i or negedge rst_n) begin
                if (!rst_n) begin
                    pin_s1_q[gi] <= 1'b0;
                    pin_s2_q[gi] <= 1'b0;
                    pin_s3_q[gi] <= 1'b0;
                    pin_q[gi] <= 1'b0;
                    pin_prev_q[gi] <= 1'b0;
                end else begin
                    pin_s1_q[gi] <= pin_raw[gi];
                    pin_s2_q[gi] <= pin_s1_q[gi];
                    pin_s3_q[gi] <= pin_s2_q[gi];
                    if (pin_s2_q[gi] == pin_s3_q[gi])
                        pin_q[gi] <= pin_s3_q[gi];
                    pin_prev_q[gi] <= pin_q[gi];
                end
            end
            assign pin_rise[gi] = pin_q[gi] & ~pin_prev_q[gi];
        end
    endgenerate

    wire clk_rise;
    wire data_bit;
    wire latch_rise;
    wire mute_level;

    assign clk_rise = pin_rise[0];
    assign data_bit = pin_q[1];
    assign latch_rise = pin_rise[2];
    assign mute_level = pin_q[3];

    // command shift register, msb first
    reg [`CMD_WIDTH-1:0] shift_q;
    wire [3:0] cmd_addr;
    wire [3:0] cmd_data;

    always @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n)
            shift_q <= {`CMD_WIDTH{1'b0}};
        else if (clk_rise)
            shift_q <= {shift_q[`CMD_WIDTH-2:0], data_bit};
    end

    assign cmd_addr = shift_q[`CMD_ADDR_HI:`CMD_ADDR_LO];
    assign cmd_data = shift_q[`CMD_DATA_HI:0];

    // control registers, write only
    reg [3:0] data_control_q;
    reg [3:0] sync_protect_attenuation_q;
    reg [3:0] track_count_lower_q;
    reg [3:0] track_count_upper_q;
    reg [3:0] spindle_hold_gain_q;
    reg [3:0] spindle_operating_mode_q;
    reg [3:0] playback_speed_select_q;
    reg [3:0] deemphasis_select_q;
    reg [3:0] status_sel_q;

    always @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            data_control_q <= `REG_RESET;
            sync_protect_attenuation_q <= `REG_RESET;
            track_count_lower_q <= `REG_RESET;
            track_count_upper_q <= `REG_RESET;
            spindle_hold_gain_q <= `REG_RESET;
            spindle_operating_mode_q <= `MODE_STOP;
            playback_speed_select_q <= `SPEED_NORMAL;
            deemphasis_select_q <= `REG_RESET;
            status_sel_q <= `STATUS_SEL_RESET;
        end else if (latch_rise) begin
            status_sel_q <= cmd_addr;
            case (cmd_addr)
                `ADDR_DATA_CONTROL: data_control_q <= cmd_data;
                `ADDR_SYNC_PROT: sync_protect_attenuation_q <= cmd_data;
                // track nibbles taken on latch rise
                `ADDR_TRK_LOWER: track_count_lower_q <= cmd_data;
                `ADDR_TRK_UPPER: track_count_upper_q <= cmd_data;
                `ADDR_HOLD_GAIN: spindle_hold_gain_q <= cmd_data;
                `ADDR_SPINDLE_MODE: spindle_operating_mode_q <= cmd_data;
                `ADDR_SPEED: playback_speed_select_q <= cmd_data;
                `ADDR_DEEMPH: deemphasis_select_q <= cmd_data;
                default: data_control_q <= data_control_q;
            endcase
        end
    end

    // frame sync protection
    frame_sync_protect #(
        .FRAME_LEN(FRAME_LEN),
        .CW(10)
    ) u_protect (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n),
        .prot_sel_i({sync_protect_attenuation_q[`BIT_PROT_HI],
                     sync_protect_attenuation_q[`BIT_PROT_LO]}),
        .window_wide_i(sync_protect_attenuation_q[`BIT_WINDOW]),
        .bit_tick_i(bit_tick_i),
        .sync_det_i(sync_det_i),
        .frame_sync_o(frame_sync_o),
        .sync_inserted_o(sync_inserted_o),
        .sync_lock_flag_o(sync_lock_flag_o),
        .sync_unlock_flag_o(sync_unlock_flag_o)
    );

    // hold clock divider; tick input shares this clock
    reg [4:0] hold_cnt_q;

    always @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            hold_cnt_q <= 5'h00;
            bottom_hold_tick_o <= 1'b0;
            peak_hold_tick_o <= 1'b0;
        end else begin
            if (crystal_frame_clock_i)
                hold_cnt_q <= hold_cnt_q + 1'b1;
            bottom_hold_tick_o <= crystal_frame_clock_i &&
                (spindle_hold_gain_q[`BIT_BOTTOM_HOLD] ?
                 (hold_cnt_q[3:0] == `HOLD_DIV16_LAST) : (hold_cnt_q == `HOLD_DIV32_LAST));
            peak_hold_tick_o <= crystal_frame_clock_i &&
                (spindle_hold_gain_q[`BIT_PEAK_HOLD] ?
                 (hold_cnt_q[0] == `HOLD_DIV2_LAST) : (hold_cnt_q[1:0] == `HOLD_DIV4_LAST));
        end
    end

    // spindle pin decode
    reg drv_d;
    reg drv_oe_n_d;
    reg vel_d;
    reg vel_oe_n_d;
    reg filt_oe_n_d;
    reg enable_d;
    wire auto_phase;

    // auto modes run phase control while sync is locked
    assign auto_phase = sync_lock_flag_o;

    always @* begin
        drv_d = 1'b0;
        drv_oe_n_d = 1'b0;
        vel_d = 1'b0;
        vel_oe_n_d = 1'b1;
        filt_oe_n_d = 1'b0;
        enable_d = 1'b1;
        case (spindle_operating_mode_q)
            `MODE_FORWARD: drv_d = 1'b1;
            `MODE_REVERSE: drv_d = 1'b0;
            `MODE_SPEED, `MODE_HSPEED: begin
                drv_d = speed_drive_i;
                drv_oe_n_d = ~speed_drive_en_i;
            end
            `MODE_PHASE: begin
                drv_d = phase_drive_i;
                vel_d = phase_velocity_i;
                vel_oe_n_d = 1'b0;
                filt_oe_n_d = 1'b1;
            end
            `MODE_XPHSP, `MODE_VPHSP: begin
                if (auto_phase) begin
                    drv_d = phase_drive_i;
                    vel_d = phase_velocity_i;
                    vel_oe_n_d = 1'b0;
                    filt_oe_n_d = 1'b1;
                end else begin
                    drv_d = speed_drive_i;
                    drv_oe_n_d = ~speed_drive_en_i;
                end
            end
            `MODE_STOP: enable_d = 1'b0;
            // undefined codes behave as stop
            default: enable_d = 1'b0;
        endcase
    end

    // registered outputs
    always @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            zero_cross_mute_o <= 1'b0;
            mute_full_o <= 1'b0;
            atten_12db_o <= 1'b0;
            deemph_internal_o <= 1'b0;
            double_speed_o <= 1'b0;
            phase_src_base_o <= 1'b0;
            gain_reduce_o <= 1'b1;
            track_count_o <= 8'h00;
            status_output_pin_o <= 1'b1;
            subcode_q_serial_out_o <= 1'b0;
            spindle_drive_output_o <= 1'b0;
            spindle_drive_oe_n_o <= 1'b0;
            spindle_velocity_output_o <= 1'b0;
            spindle_velocity_oe_n_o <= 1'b1;
            spindle_filter_control_o <= 1'b0;
            spindle_filter_oe_n_o <= 1'b0;
            spindle_servo_enable_o <= 1'b0;
        end else begin
            zero_cross_mute_o <= data_control_q[`BIT_ZERO_CROSS];
            phase_src_base_o <= data_control_q[`BIT_PHASE_SRC];
            atten_12db_o <= sync_protect_attenuation_q[`BIT_ATTEN];
            mute_full_o <= ~sync_protect_attenuation_q[`BIT_ATTEN] & mute_level;
            gain_reduce_o <= ~spindle_hold_gain_q[`BIT_GAIN];
            double_speed_o <= (playback_speed_select_q == `SPEED_DOUBLE);
            deemph_internal_o <= deemphasis_select_q[`BIT_DEEMPH];
            track_count_o <= {track_count_upper_q, track_count_lower_q};
            if (data_control_q[`BIT_CRC_INCLUDE] && subcode_sync_signal_i)
                subcode_q_serial_out_o <= crc_good_indication_i;
            else
                subcode_q_serial_out_o <= subcode_q_data_i;
            case (status_sel_q)
                `ADDR_DATA_CONTROL: status_output_pin_o <= subcode_sync_signal_i;
                `ADDR_SYNC_PROT: status_output_pin_o <= sync_lock_flag_o;
                `ADDR_TRK_LOWER: status_output_pin_o <= jump_complete_n_i;
                `ADDR_TRK_UPPER: status_output_pin_o <= track_count_pulse_n_i;
                default: status_output_pin_o <= 1'b1;
            endcase
            spindle_drive_output_o <= drv_d;
            spindle_drive_oe_n_o <= drv_oe_n_d;
            spindle_velocity_output_o <= vel_d;
            spindle_velocity_oe_n_o <= vel_oe_n_d;
            spindle_filter_control_o <= 1'b0;
            spindle_filter_oe_n_o <= filt_oe_n_d;
            spindle_servo_enable_o <= enable_d;
        end
    end
endmodule // cd_dsp_control_registers
`default_nettype wire

// ==== bench/cd_dsp_ctrl_sva.sv ====
// checker for the control register block: sync flags, mute, spindle pins
// assumes it is bound into cd_dsp_control_registers
`timescale 1ns/1ps
`default_nettype none
module cd_dsp_ctrl_sva (
    // clock and reset
    input wire clk_sys_i,
    input wire nrst_i,
    // watched ports
    input wire mute_full_o,
    input wire atten_12db_o,
    input wire bit_tick_i,
    input wire sync_det_i,
    input wire frame_sync_o,
    input wire sync_inserted_o,
    input wire sync_lock_flag_o,
    input wire sync_unlock_flag_o,
    input wire spindle_drive_output_o,
    input wire spindle_drive_oe_n_o,
    input wire spindle_velocity_oe_n_o,
    input wire spindle_servo_enable_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    logic [4:0] ins_q;
    // inserts since last accepted sync, saturating
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ins_q <= 5'h00;
        end else if (sync_inserted_o) begin
            ins_q <= (ins_q == 5'h1F) ? ins_q : ins_q + 5'h01;
        end else if (frame_sync_o) begin
            ins_q <= 5'h00;
        end
    end
    AST_MUTE_ATTEN: assert property (mute_full_o |-> !atten_12db_o)
        else $error("full mute while attenuating");
    AST_LOCK_EXCL: assert property (sync_lock_flag_o |-> !sync_unlock_flag_o)
        else $error("lock and unlock both high");
    AST_INS_FS: assert property (sync_inserted_o |-> frame_sync_o)
        else $error("insert without frame sync");
    AST_FS_CAUSE: assert property (frame_sync_o && !sync_inserted_o |->
        $past(sync_det_i && bit_tick_i))
        else $error("frame sync without detection");
    AST_UNLK_SET: assert property ($rose(sync_unlock_flag_o) |->
        sync_inserted_o || $past(sync_inserted_o))
        else $error("unlock rose without insert");
    AST_UNLK_CNT: assert property ($rose(sync_unlock_flag_o) |->
        (ins_q + {4'h0, sync_inserted_o}) >= 5'h02)
        else $error("unlock after too few inserts");
    AST_UNLK_CLR: assert property ($fell(sync_unlock_flag_o) |->
        frame_sync_o || $past(frame_sync_o))
        else $error("unlock fell without sync");
    AST_INS_NOLOCK: assert property (sync_inserted_o |=> !sync_lock_flag_o)
        else $error("lock held after insert");
    AST_STOP_PINS: assert property (!spindle_servo_enable_o |-> !spindle_drive_output_o
        && !spindle_drive_oe_n_o && spindle_velocity_oe_n_o)
        else $error("stop pins wrong");
    cover property ($rose(sync_unlock_flag_o));
    cover property ($rose(sync_lock_flag_o));
    cover property (sync_inserted_o);
    cover property (mute_full_o);
endmodule // cd_dsp_ctrl_sva
bind cd_dsp_control_registers cd_dsp_ctrl_sva u_sva (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .mute_full_o(mute_full_o),
    .atten_12db_o(atten_12db_o), .bit_tick_i(bit_tick_i), .sync_det_i(sync_det_i),
    .frame_sync_o(frame_sync_o), .sync_inserted_o(sync_inserted_o),
    .sync_lock_flag_o(sync_lock_flag_o), .sync_unlock_flag_o(sync_unlock_flag_o),
    .spindle_drive_output_o(spindle_drive_output_o),
    .spindle_drive_oe_n_o(spindle_drive_oe_n_o),
    .spindle_velocity_oe_n_o(spindle_velocity_oe_n_o),
    .spindle_servo_enable_o(spindle_servo_enable_o)
);
`default_nettype wire

// ==== bench/host_cmd_model.sv ====
// host side of the three-wire command port
// assumes pins are sampled on clk_sys_i through synchronisers
`timescale 1ns/1ps
`default_nettype none
module host_cmd_model (
    // clock
    input wire clk_sys_i,
    // command pins
    output logic command_clock_o,
    output logic command_data_o,
    output logic command_latch_o
);
    initial begin
        command_clock_o = 1'b0;
        command_data_o = 1'b0;
        command_latch_o = 1'b0;
    end
    task automatic hold(input int k);
        repeat (k) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic send(input logic [7:0] w);
        for (int i = 7; i >= 0; i--) begin
            command_data_o = w[i];
            hold(4);
            command_clock_o = 1'b1;
            hold(4);
            command_clock_o = 1'b0;
            hold(2);
            // stale bit flipped so it cannot pass as valid
            command_data_o = ~w[i];
            hold(2);
        end
        command_latch_o = 1'b1;
        hold(4);
        command_latch_o = 1'b0;
        hold(10);
    endtask
endmodule // host_cmd_model
`default_nettype wire

// ==== bench/tb_top.sv ====
// testbench: register writes over the command port, sync protection
// assumes the design header is on the include path
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int FL = 40;
    logic clk_sys_i, nrst_i, mute, ftick, sdet, qd, qok, qsync, jc_n, tc_n, fsv;
    wire cc, cdat, clat, zcm, mfull, att, deem, dbl, psrc, btick, ptick, gred, stat, sqo;
    wire fs, ins, lock, unlk, sdrv, sdrv_oe_n, svel_oe_n, sfil_oe_n, sen;
    wire [7:0] trk;
    int mismatches, n_compared, n;
    logic [3:0] mc [8] = '{4'h8, 4'hA, 4'hF, 4'h0, 4'hE, 4'hC, 4'h6, 4'h5};
    logic [7:0] mx [4] = '{8'h2A, 8'h28, 8'h24, 8'h08};
    logic [7:0] pc [4] = '{8'd2, 8'd4, 8'd8, 8'd13};
    host_cmd_model u_host (.clk_sys_i(clk_sys_i), .command_clock_o(cc),
        .command_data_o(cdat), .command_latch_o(clat));
    cd_dsp_control_registers #(.FRAME_LEN(FL)) DUT (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .command_clock_i(cc), .command_data_i(cdat), .command_latch_i(clat),
        .mute_pin_i(mute), .crystal_frame_clock_i(ftick), .bit_tick_i(1'b1),
        .sync_det_i(sdet), .subcode_q_data_i(qd), .crc_good_indication_i(qok),
        .subcode_sync_signal_i(qsync), .jump_complete_n_i(jc_n),
        .track_count_pulse_n_i(tc_n), .speed_drive_i(1'b0), .speed_drive_en_i(1'b0),
        .phase_drive_i(1'b0), .phase_velocity_i(1'b0), .zero_cross_mute_o(zcm),
        .mute_full_o(mfull), .atten_12db_o(att), .deemph_internal_o(deem),
        .double_speed_o(dbl), .phase_src_base_o(psrc), .bottom_hold_tick_o(btick),
        .peak_hold_tick_o(ptick), .gain_reduce_o(gred), .track_count_o(trk),
        .status_output_pin_o(stat), .subcode_q_serial_out_o(sqo), .frame_sync_o(fs),
        .sync_inserted_o(ins), .sync_lock_flag_o(lock), .sync_unlock_flag_o(unlk),
        .spindle_drive_output_o(sdrv), .spindle_drive_oe_n_o(sdrv_oe_n),
        .spindle_velocity_output_o(), .spindle_velocity_oe_n_o(svel_oe_n),
        .spindle_filter_control_o(), .spindle_filter_oe_n_o(sfil_oe_n),
        .spindle_servo_enable_o(sen));
    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) ftick <= #1 ~ftick;
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [3:0] d);
        u_host.send({a, d});
    endtask
    // cycles between two pulses of a hold tick
    task automatic per(input logic sel, output int p);
        p = 0;
        for (int k = 0; k < 200 && (sel ? btick : ptick) !== 1'b1; k++) cyc(1);
        cyc(1);
        while (p < 200 && (sel ? btick : ptick) !== 1'b1) begin
            p++;
            cyc(1);
        end
        p++;
    endtask
    // waits for the unlock level, counting inserts meanwhile
    task automatic wait_unlk(input logic lvl);
        n = 0;
        for (int k = 0; k < 1200 && unlk !== lvl; k++) begin
            cyc(1);
            n += int'(ins);
        end
        if (unlk !== lvl) begin
            mismatches++;
            test_done();
        end
    endtask
    task automatic pulse;
        sdet = 1'b1;
        cyc(1);
        sdet = 1'b0;
        fsv = fs;
    endtask
    initial begin
        {nrst_i, mute, ftick, sdet, qd, qsync, fsv} = 7'h00;
        {qok, jc_n, tc_n} = 3'b111;
        mismatches = 0;
        n_compared = 0;
        cyc(8);
        nrst_i = 1'b1;
        cyc(4);
        chk({deem, gred, stat, sen}, 8'h06);
        wr(4'h9, 4'hB);
        qsync = 1'b1;
        cyc(8);
        chk({zcm, psrc, sqo}, 8'h07);
        wr(4'h9, 4'h0);
        chk({zcm, psrc, sqo}, 8'h00);
        for (int i = 0; i < 4; i++) begin
            mute = i[1];
            wr(4'hA, {3'b000, i[0]});
            chk({mfull, att}, {6'h00, ~i[0] & i[1], i[0]});
        end
        wr(4'hB, 4'h5);
        jc_n = 1'b0;
        cyc(6);
        chk(stat, 8'h00);
        wr(4'hC, 4'hA);
        chk({trk[7:1], stat}, {8'hA5} & 8'hFE | 8'h01);
        wr(4'h3, 4'hF);
        chk({stat, deem}, 8'h02);
        for (int i = 0; i < 2; i++) begin
            wr(4'hD, i ? 4'h7 : 4'h0);
            chk(gred, i ? 8'h00 : 8'h01);
            per(1'b1, n);
            chk(n[7:0], i ? 8'd32 : 8'd64);
            per(1'b0, n);
            chk(n[7:0], i ? 8'd4 : 8'd8);
        end
        wr(4'hA, 4'h1);
        for (int i = 0; i < 8; i++) begin
            wr(4'hE, mc[i]);
            if (i < 4) chk({sen, sdrv_oe_n, svel_oe_n, sfil_oe_n, sdrv, 1'b0}, mx[i]);
            else chk(sen, 8'h01);
        end
        wr(4'hF, 4'h3);
        wr(4'h8, 4'h2);
        chk({dbl, deem}, 8'h03);
        wr(4'hF, 4'h0);
        wr(4'h8, 4'hD);
        chk({dbl, deem}, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(4'hA, {i[1:0], 2'b00});
            wait_unlk(1'b1);
            pulse();
            chk(fsv, 8'h01);
            wait_unlk(1'b0);
            wait_unlk(1'b1);
            chk(n[7:0], pc[i]);
        end
        pulse();
        cyc(FL - 1);
        pulse();
        cyc(2);
        chk({lock, unlk}, 8'h02);
        cyc(FL / 2);
        pulse();
        chk({fsv, lock}, 8'h01);
        test_done();
    end
endmodule // tb_top
`default_nettype wire
